// ===== core/bsi_pkg.sv
// Constants for the tester's status, interrupt-enable and pattern capture unit
package bsi_pkg;
  // ==========================================================================
  // Register map of the 8-bit host port
  localparam logic [7:0] ADDR_RX_PATTERN_BYTE3      = 8'h10;
  localparam logic [7:0] ADDR_RX_PATTERN_BYTE2      = 8'h11;
  localparam logic [7:0] ADDR_RX_PATTERN_BYTE1      = 8'h12;
  localparam logic [7:0] ADDR_RX_PATTERN_BYTE0      = 8'h13;
  localparam logic [7:0] ADDR_EVENT_STATUS          = 8'h14;
  localparam logic [7:0] ADDR_EVENT_INTERRUPT_ENABLE = 8'h15;
  localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;
  // ==========================================================================
  // Status and enable bit positions
  localparam int BIT_ALL_ONES          = 6;
  localparam int BIT_ALL_ZEROS         = 5;
  localparam int BIT_SYNC_LOSS         = 4;
  localparam int BIT_ERROR_SEEN        = 3;
  localparam int BIT_BIT_COUNT_OVF     = 2;
  localparam int BIT_ERROR_COUNT_OVF   = 1;
  localparam int BIT_SYNC_LIVE         = 0;
  localparam int FLAG_TOP              = 6;
  localparam int FLAG_LOW              = 1;
  localparam int COND_LOW              = 4;
  // ==========================================================================
  // Reset values and detector figures
  localparam logic [7:0] RESET_INTERRUPT_ENABLE = 8'h00;
  localparam logic [6:1] RESET_FLAGS            = 6'h00;
  localparam int         RUN_W                  = 6;
  localparam logic [5:0] RUN_LEN                = 6'h20;  // 32 equal bits
  localparam logic [5:0] WIN_LAST               = 6'h3F;  // 64-bit window
  localparam int         ERR_W                  = 3;
  localparam logic [2:0] ERR_LIMIT              = 3'h6;   // 6 errors per window
  localparam int         PAT_W                  = 32;
endpackage

// ===== core/bsi_status_unit.sv
// Status flags, interrupt enables, live sync monitor and pattern capture
`timescale 1ns/10ps
module bsi_status_unit
  import bsi_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             host_cs,
  input  wire logic             host_rd,
  input  wire logic             host_wr,
  input  wire logic [7:0]       host_addr,
  input  wire logic [7:0]       host_wdata,
  output logic      [7:0]       host_rdata,
  output logic                  host_rdata_oe,
  input  wire logic             rx_bit_valid,
  input  wire logic             rx_data,
  input  wire logic             rx_bit_error,
  input  wire logic             sync_declared,
  input  wire logic [PAT_W-1:0] sync_pattern,
  input  wire logic             pattern_control_bit2,
  input  wire logic             pattern_latch_request,
  input  wire logic             received_bit_counter_wrap,
  input  wire logic             bit_error_counter_wrap,
  output logic                  int_n_o,
  output logic                  int_n_oe
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [6:1]       flags;
    logic [6:1]       read_snap;
    logic [6:1]       ev_during;
    logic             rd_status;
    logic             rd_prev;
    logic [7:0]       irq_enable;
    logic             sync_live;
    logic [RUN_W-1:0] ones_run;
    logic [RUN_W-1:0] zeros_run;
    logic [RUN_W-1:0] win_pos;
    logic [ERR_W-1:0] win_errs;
    logic [PAT_W-1:0] shift;
    logic [PAT_W-1:0] pattern;
    logic             latch_prev;
    logic [7:0]       rdata;
  } bsi_state_s;

  bsi_state_s s_q;
  bsi_state_s s_d;

  logic [6:1] ev;
  logic [6:1] cond;
  logic [6:1] clr;
  logic       rd_start;
  logic       rd_end;
  logic [7:0] status_view;
  logic       irq_active;

  // ==========================================================================
  // Event sources
  always_comb begin
    ev   = '0;
    cond = '0;
    cond[BIT_ALL_ONES]  = (s_q.ones_run == RUN_LEN);
    cond[BIT_ALL_ZEROS] = (s_q.zeros_run == RUN_LEN);
    cond[BIT_SYNC_LOSS] = !s_q.sync_live;
    ev[BIT_ALL_ONES]    = cond[BIT_ALL_ONES];
    ev[BIT_ALL_ZEROS]   = cond[BIT_ALL_ZEROS];
    ev[BIT_SYNC_LOSS]   = cond[BIT_SYNC_LOSS];
    ev[BIT_ERROR_SEEN]  = rx_bit_valid && rx_bit_error;
    ev[BIT_BIT_COUNT_OVF]   = received_bit_counter_wrap;
    ev[BIT_ERROR_COUNT_OVF] = bit_error_counter_wrap;
  end

  // Bit 7 has no storage; zero is one legal undefined value
  assign status_view = {1'b0, s_q.flags, s_q.sync_live};

  assign rd_start = host_cs && host_rd && !s_q.rd_prev;
  assign rd_end   = s_q.rd_prev && !(host_cs && host_rd);

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    clr = '0;
    s_d.rd_prev = host_cs && host_rd;

    // Run-length detectors saturate so the level holds while the run lasts
    if (rx_bit_valid) begin
      s_d.shift = {s_q.shift[PAT_W-2:0], rx_data};
      if (rx_data) begin
        s_d.zeros_run = '0;
        if (s_q.ones_run != RUN_LEN) begin
          s_d.ones_run = s_q.ones_run + 1'b1;
        end
      end else begin
        s_d.ones_run = '0;
        if (s_q.zeros_run != RUN_LEN) begin
          s_d.zeros_run = s_q.zeros_run + 1'b1;
        end
      end
    end

    // Live sync with a 64-bit error window
    if (sync_declared) begin
      s_d.sync_live = 1'b1;
      s_d.win_pos   = '0;
      s_d.win_errs  = '0;
    end else if (s_q.sync_live && rx_bit_valid) begin
      s_d.win_pos = s_q.win_pos + 1'b1;
      if (rx_bit_error && s_q.win_errs != ERR_LIMIT) begin
        s_d.win_errs = s_q.win_errs + 1'b1;
      end
      if (!pattern_control_bit2 && rx_bit_error &&
          (s_q.win_errs + 3'h1) == ERR_LIMIT) begin
        s_d.sync_live = 1'b0;
        s_d.win_pos   = '0;
        s_d.win_errs  = '0;
      end else if (s_q.win_pos == WIN_LAST) begin
        s_d.win_errs = '0;
      end
    end

    // Pattern capture on the rising edge of the latch request
    s_d.latch_prev = pattern_latch_request;
    if (pattern_latch_request && !s_q.latch_prev) begin
      s_d.pattern = s_q.sync_live ? sync_pattern : s_q.shift;
    end

    // Host write; bit 7 is stored as written
    if (host_cs && host_wr && host_addr == ADDR_EVENT_INTERRUPT_ENABLE) begin
      s_d.irq_enable = host_wdata;
    end

    // Host read: data is taken at the start, flags clear at the end
    if (rd_start) begin
      s_d.rd_status = (host_addr == ADDR_EVENT_STATUS);
      s_d.read_snap = s_q.flags;
      s_d.ev_during = '0;
      case (host_addr)
        ADDR_RX_PATTERN_BYTE3:       s_d.rdata = s_q.pattern[31:24];
        ADDR_RX_PATTERN_BYTE2:       s_d.rdata = s_q.pattern[23:16];
        ADDR_RX_PATTERN_BYTE1:       s_d.rdata = s_q.pattern[15:8];
        ADDR_RX_PATTERN_BYTE0:       s_d.rdata = s_q.pattern[7:0];
        ADDR_EVENT_STATUS:           s_d.rdata = status_view;
        ADDR_EVENT_INTERRUPT_ENABLE: s_d.rdata = s_q.irq_enable;
        default:                     s_d.rdata = UNMAPPED_READ_VALUE;
      endcase
    end else if (s_q.rd_prev) begin
      s_d.ev_during = s_q.ev_during | ev;
    end

    // A flag whose event recurred during the read was not seen by the host
    if (rd_end && s_q.rd_status) begin
      for (int i = FLAG_LOW; i <= FLAG_TOP; i++) begin
        clr[i] = s_q.read_snap[i] && !s_q.ev_during[i] && !ev[i];
        if (i >= COND_LOW) begin
          clr[i] = clr[i] && !cond[i];
        end
      end
      s_d.rd_status = 1'b0;
    end
    s_d.flags = (s_q.flags & ~clr) | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q            <= '0;
      s_q.irq_enable <= RESET_INTERRUPT_ENABLE;
      s_q.flags      <= RESET_FLAGS;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign irq_active    = |(status_view[6:0] & s_q.irq_enable[6:0]);
  assign int_n_o       = 1'b0;
  assign int_n_oe      = irq_active;
  assign host_rdata    = s_q.rdata;
  assign host_rdata_oe = host_cs && host_rd;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_status_read_end;
    s_q.rd_status && rd_end;
  endsequence

  property p_ones_set;
    (s_q.ones_run == RUN_LEN) |=> s_q.flags[BIT_ALL_ONES];
  endproperty
  a_ones_set: assert property (p_ones_set) else $error("all-ones flag missed");

  property p_zeros_set;
    (s_q.zeros_run == RUN_LEN) |=> s_q.flags[BIT_ALL_ZEROS];
  endproperty
  a_zeros_set: assert property (p_zeros_set) else $error("all-zeros flag missed");

  property p_loss_set;
    !s_q.sync_live |=> s_q.flags[BIT_SYNC_LOSS];
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("sync-loss flag missed");

  property p_err_set;
    (rx_bit_valid && rx_bit_error) |=> s_q.flags[BIT_ERROR_SEEN];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error-seen flag missed");

  property p_ovf_set;
    received_bit_counter_wrap |=> s_q.flags[BIT_BIT_COUNT_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("bit overflow flag missed");

  property p_eovf_set;
    bit_error_counter_wrap |=> s_q.flags[BIT_ERROR_COUNT_OVF];
  endproperty
  a_eovf_set: assert property (p_eovf_set) else $error("error overflow missed");

  property p_sync_live;
    sync_declared |=> s_q.sync_live && host_rdata_oe == (host_cs && host_rd);
  endproperty
  a_sync_live: assert property (p_sync_live) else $error("sync not declared");

  property p_err_clear;
    (s_status_read_end and (s_q.read_snap[BIT_ERROR_SEEN] &&
      !s_q.ev_during[BIT_ERROR_SEEN] && !ev[BIT_ERROR_SEEN]))
      |=> !s_q.flags[BIT_ERROR_SEEN];
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_cond_hold;
    (s_status_read_end and cond[BIT_ALL_ONES]) |=> s_q.flags[BIT_ALL_ONES];
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("all-ones cleared early");

  property p_irq;
    (s_q.flags[BIT_ERROR_SEEN] && s_q.irq_enable[BIT_ERROR_SEEN])
      |-> int_n_oe && !int_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not driven");

  property p_capture;
    (pattern_latch_request && !s_q.latch_prev && !s_q.sync_live)
      |=> s_q.pattern == $past(s_q.shift);
  endproperty
  a_capture: assert property (p_capture) else $error("pattern not captured");

  // Sixth error of the window, counted before the window can restart
  sequence s_sixth_error;
    s_q.sync_live && !sync_declared && rx_bit_valid && rx_bit_error &&
      (s_q.win_errs + 3'h1) == ERR_LIMIT;
  endsequence

  sequence s_status_read_start;
    rd_start && host_addr == ADDR_EVENT_STATUS;
  endsequence

  property p_sync_drop;
    (s_sixth_error and !pattern_control_bit2) |=> !s_q.sync_live;
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("sync not dropped");

  property p_sync_hold;
    (s_sixth_error and pattern_control_bit2) |=> s_q.sync_live;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync dropped");

  property p_mask_off;
    (s_q.irq_enable[6:0] == 7'h00) |-> !int_n_oe;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked interrupt driven");

  property p_status_bit7;
    s_status_read_start |=> !host_rdata[7];
  endproperty
  a_status_bit7: assert property (p_status_bit7) else $error("status bit 7 set");

  property p_sync_mirror;
    s_status_read_start |=> host_rdata[BIT_SYNC_LIVE] == $past(s_q.sync_live);
  endproperty
  a_sync_mirror: assert property (p_sync_mirror) else $error("sync bit stale");

  // Events seen during the read must survive the clear at its end
  property p_keep_during;
    (s_status_read_end and (|s_q.ev_during))
      |=> (s_q.flags & $past(s_q.ev_during)) == $past(s_q.ev_during);
  endproperty
  a_keep_during: assert property (p_keep_during) else $error("event lost on read");

  property p_capture_sync;
    (pattern_latch_request && !s_q.latch_prev && s_q.sync_live)
      |=> s_q.pattern == $past(sync_pattern);
  endproperty
  a_capture_sync: assert property (p_capture_sync) else $error("locked pattern missed");

endmodule // bsi_status_unit

// ===== tb/bsi_host_model.sv
// Host processor model for the 8-bit register port
`timescale 1ns/10ps
module bsi_host_model (
  input  wire logic       clk,
  output logic            host_cs,
  output logic            host_rd,
  output logic            host_wr,
  output logic [7:0]      host_addr,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  initial begin
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end
  // Strobe held past the answer edge; the idle edge after it ends the read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    host_cs <= 1'b1;
    host_rd <= 1'b1;
    host_addr <= a;
    repeat (3) @(posedge clk);
    d = host_rdata;
    host_cs <= 1'b0;
    host_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_cs <= 1'b1;
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= {1'b0, d[6:0]};
    @(posedge clk);
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    host_wdata <= ~host_wdata;
    @(posedge clk);
  endtask
endmodule // bsi_host_model

// ===== tb/bsi_status_unit_bench.sv
// Self-checking bench for the status and interrupt-enable unit
`timescale 1ns/10ps
module bsi_status_unit_bench
  import bsi_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        host_cs, host_rd, host_wr, rdata_oe, int_o, int_oe;
  logic [7:0]  host_addr, host_wdata, host_rdata, r;
  logic        rx_v = 1'b0, rx_d = 1'b0, rx_e = 1'b0, ctl2 = 1'b0, latch = 1'b0;
  logic [2:0]  pls = 3'b000;
  logic [31:0] sync_pat = 32'h0000_0000;
  int          fail_count = 0, check_count = 0, cyc = 0;
  wire         int_n = int_oe ? int_o : 1'b1;  // Board pull-up on the pin

  always #12.5 clk = ~clk;
  bsi_host_model host (.clk(clk), .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
  bsi_status_unit dut (.clk(clk), .rst(rst), .host_cs(host_cs), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rdata_oe(rdata_oe), .rx_bit_valid(rx_v),
    .rx_data(rx_d), .rx_bit_error(rx_e), .sync_declared(pls[2]), .sync_pattern(sync_pat),
    .pattern_control_bit2(ctl2), .pattern_latch_request(latch),
    .received_bit_counter_wrap(pls[1]), .bit_error_counter_wrap(pls[0]),
    .int_n_o(int_o), .int_n_oe(int_oe));

  // ==========================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    host.rd(ADDR_EVENT_STATUS, r);
    chk("status", r & m, e);
  endtask
  task automatic bits(input int n, input logic d, input logic e);
    repeat (n) begin
      @(posedge clk);
      rx_v <= 1'b1;
      rx_d <= d;
      rx_e <= e;
    end
    @(posedge clk);
    rx_v <= 1'b0;
    rx_e <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    pls <= p;
    @(posedge clk);
    pls <= 3'b000;
    repeat (2) @(posedge clk);
  endtask
  task automatic grab(input logic [31:0] e);
    @(posedge clk);
    latch <= 1'b1;
    repeat (2) @(posedge clk);
    latch <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.rd(ADDR_RX_PATTERN_BYTE3 + 8'(i), r);
      chk("pattern", r, e[31-8*i -: 8]);
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("int_pin", int_n, 1'b1);
    chk("rdata_oe", rdata_oe, 1'b0);
    st(8'hFF, 8'h10);
    st(8'hFF, 8'h10);
    host.wr(ADDR_EVENT_STATUS, 8'h7F);
    fork
      host.rd(ADDR_EVENT_INTERRUPT_ENABLE, r);
      begin
        repeat (2) @(posedge clk);
        chk("rdata_oe", rdata_oe, 1'b1);
      end
    join
    chk("enable", r, RESET_INTERRUPT_ENABLE);
    host.rd(8'h20, r);
    chk("unmapped", r, UNMAPPED_READ_VALUE);
    $display("test reset done");
  endtask
  task automatic t_events();
    bits(1, 1'b0, 1'b1);
    pulse(3'b011);
    host.wr(ADDR_EVENT_INTERRUPT_ENABLE, 8'hE1);
    chk("int_masked", int_n, 1'b1);
    host.rd(ADDR_EVENT_INTERRUPT_ENABLE, r);
    chk("enable", r, 8'h61);
    host.wr(ADDR_EVENT_INTERRUPT_ENABLE, 8'h08);
    repeat (10) @(posedge clk);
    chk("int_on", int_n, 1'b0);
    st(8'hFF, 8'h1E);
    repeat (2) @(posedge clk);
    chk("int_off", int_n, 1'b1);
    st(8'hFF, 8'h10);
    pulse(3'b001);
    fork
      host.rd(ADDR_EVENT_STATUS, r);
      begin
        repeat (3) @(posedge clk);
        pls <= 3'b001;
        @(posedge clk);
        pls <= 3'b000;
      end
    join
    chk("status", r, 8'h12);
    st(8'h02, 8'h02);
    host.wr(ADDR_EVENT_INTERRUPT_ENABLE, 8'h00);
    $display("test events done");
  endtask
  task automatic t_runs();
    for (int v = 1; v >= 0; v--) begin
      bits(1, ~v[0], 1'b0);
      bits(31, v[0], 1'b0);
      st(8'h60, 8'h00);
      bits(1, v[0], 1'b0);
      st(8'h60, v ? 8'h40 : 8'h20);
      st(8'h60, v ? 8'h40 : 8'h20);
      bits(1, ~v[0], 1'b0);
      st(8'h60, v ? 8'h40 : 8'h20);
      st(8'h60, 8'h00);
    end
    $display("test runs done");
  endtask
  task automatic t_sync();
    pulse(3'b100);
    st(8'h11, 8'h11);
    st(8'h11, 8'h01);
    host.wr(ADDR_EVENT_INTERRUPT_ENABLE, 8'h01);
    chk("int_sync", int_n, 1'b0);
    bits(5, 1'b1, 1'b1);
    st(8'h01, 8'h01);
    bits(1, 1'b1, 1'b1);
    st(8'h11, 8'h10);
    chk("int_sync", int_n, 1'b1);
    $display("test sync done");
  endtask
  task automatic t_latch();
    for (int i = 31; i >= 0; i--) bits(1, 1'(32'hA5C3_0F96 >> i), 1'b0);
    grab(32'hA5C3_0F96);
    @(posedge clk);
    sync_pat <= 32'h1234_5678;
    ctl2 <= 1'b1;
    pulse(3'b100);
    grab(32'h1234_5678);
    bits(6, 1'b0, 1'b1);
    st(8'h01, 8'h01);
    $display("test latch done");
  endtask

  // ==========================================
  // Run control
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_runs();
    t_sync();
    t_latch();
    print_verdict();
  end
endmodule // bsi_status_unit_bench
